/* rtl/npc_pkg.sv */
`default_nettype none
package npc_pkg;
   localparam logic [7:0]  OFS_BSEL   = 8'h00;
   localparam logic [7:0]  OFS_PSC    = 8'h04;
   localparam logic [7:0]  OFS_APC    = 8'h08;
   localparam logic [7:0]  OFS_OPT    = 8'h0c;
   localparam logic [7:0]  OFS_AADDR  = 8'h10;
   localparam logic [7:0]  OFS_ADATA  = 8'h14;
   localparam logic [2:0]  SEL_BSEL   = 3'h0;
   localparam logic [2:0]  SEL_PSC    = 3'h1;
   localparam logic [2:0]  SEL_APC    = 3'h2;
   localparam logic [2:0]  SEL_OPT    = 3'h3;
   localparam logic [2:0]  SEL_AADDR  = 3'h4;
   localparam logic [2:0]  SEL_ADATA  = 3'h5;
   localparam logic [2:0]  SEL_NONE   = 3'h7;
   localparam int          PSC_ROWZ   = 0;
   localparam int          PSC_PGM    = 1;
   localparam int          PSC_SENSE  = 7;
   localparam int          APC_POWER  = 0;
   localparam int          APC_OPTPWR = 1;
   localparam int          APC_LATCH  = 2;
   localparam int          OPT_PDI    = 0;
   localparam int          OPT_DELAY  = 1;
   localparam int          OPT_LEVEL  = 6;
   localparam logic [11:0] STOP_DLY_LONG  = 12'hfe0;
   localparam logic [11:0] STOP_DLY_SHORT = 12'h010;
   localparam logic [7:0]  BSEL_RESET = 8'h00;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam int          ARRAY_AW   = 13;
   typedef struct packed {
      logic latch;
      logic opt_power;
      logic power;
   } npc_apc_s;
   localparam npc_apc_s APC_RESET = '{latch: 1'b0, opt_power: 1'b0,
                                      power: 1'b0};
endpackage
`default_nettype wire

/* rtl/npc_nvm_ctrl.sv */
`default_nettype none
module npc_nvm_ctrl
   import npc_pkg::*;
(
   // clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // axi4-lite write
   input  wire logic [7:0]          awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   // axi4-lite read
   input  wire logic [7:0]          araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   // programming supply and erase
   input  wire logic                vpp_applied,
   input  wire logic                nv_erase,
   // main array
   input  wire logic [7:0]          array_rdata,
   output logic [ARRAY_AW-1:0]      array_addr_o,
   output logic [7:0]               array_wdata_o,
   output logic                     array_wstb_o,
   output logic                     array_latch_mode_o,
   output logic                     array_vpp_o,
   output logic                     option_vpp_o,
   output logic                     cell_vpp_o,
   // option outputs
   input  wire logic [15:0]         pulldown_req,
   output logic [15:0]              pulldown_en_o,
   output logic [7:0]               option_bits_o,
   output logic [11:0]              stop_delay_cycles_o,
   output logic                     irq_level_sense_o
);

   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      case (a)
         OFS_BSEL:  reg_sel = SEL_BSEL;
         OFS_PSC:   reg_sel = SEL_PSC;
         OFS_APC:   reg_sel = SEL_APC;
         OFS_OPT:   reg_sel = SEL_OPT;
         OFS_AADDR: reg_sel = SEL_AADDR;
         OFS_ADATA: reg_sel = SEL_ADATA;
         default:   reg_sel = SEL_NONE;
      endcase
   endfunction

   // index equals column*8 + row, i.e. the low six bits unchanged
   function automatic logic [5:0] cell_index_of(input logic [7:0] s);
      cell_index_of = {s[5:3], s[2:0]};
   endfunction

   logic [7:0]          awaddr_q;
   logic [7:0]          wdata_q;
   logic [4:0]          wdata_hi_q;
   logic                wstb0_q;
   logic                aw_have_r;
   logic                w_have_r;
   logic                wr_go;
   logic [2:0]          wsel;
   logic [7:0]          bsel_r;
   logic                pgm_r;
   logic                sensed_r;
   npc_apc_s            apc_r;
   logic [7:0]          opt_pend_r;
   logic [7:0]          opt_nv_r;
   logic [63:0]         cells_r;
   logic [ARRAY_AW-1:0] aaddr_r;
   logic [7:0]          rd_val;
   logic                rd_err;

   assign wr_go = aw_have_r && w_have_r && !bvalid;
   assign wsel  = reg_sel(awaddr_q);

   // write address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         awready   <= 1'b0;
         awaddr_q  <= 8'h00;
      end else if (awvalid && awready) begin
         aw_have_r <= 1'b1;
         awready   <= 1'b0;
         awaddr_q  <= awaddr;
      end else if (bvalid && bready) begin
         aw_have_r <= 1'b0;
         awready   <= 1'b1;
      end else if (!aw_have_r) begin
         awready   <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_r <= 1'b0;
         wready   <= 1'b0;
         wdata_q  <= 8'h00;
         wdata_hi_q <= 5'h00;
         wstb0_q  <= 1'b0;
      end else if (wvalid && wready) begin
         w_have_r <= 1'b1;
         wready   <= 1'b0;
         wdata_q  <= wdata[7:0];
         wdata_hi_q <= wdata[ARRAY_AW-1:8];
         wstb0_q  <= wstrb[0];
      end else if (bvalid && bready) begin
         w_have_r <= 1'b0;
         wready   <= 1'b1;
      end else if (!w_have_r) begin
         wready   <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // select register: all eight bits are software storage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bsel_r <= BSEL_RESET;
      end else if (wr_go && wstb0_q && wsel == SEL_BSEL) begin
         bsel_r <= wdata_q;
      end
   end

   // only the program bit of status/control is writable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pgm_r <= 1'b0;
      end else if (wr_go && wstb0_q && wsel == SEL_PSC) begin
         pgm_r <= wdata_q[PSC_PGM];
      end
   end

   // power needs the latch already set and staying set in this write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         apc_r <= APC_RESET;
      end else if (wr_go && wstb0_q && wsel == SEL_APC) begin
         apc_r.latch     <= wdata_q[APC_LATCH];
         apc_r.opt_power <= wdata_q[APC_OPTPWR];
         apc_r.power     <= wdata_q[APC_POWER] && apc_r.latch
                            && wdata_q[APC_LATCH];
      end
   end

   // staged option value, burned only while option power is on
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opt_pend_r <= 8'h00;
      end else if (wr_go && wstb0_q && wsel == SEL_OPT) begin
         opt_pend_r <= wdata_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aaddr_r <= '0;
      end else if (wr_go && wstb0_q && wsel == SEL_AADDR) begin
         aaddr_r <= {wdata_hi_q, wdata_q};
      end
   end

   // array write is only meaningful in latch mode; otherwise dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         array_addr_o  <= '0;
         array_wdata_o <= 8'h00;
         array_wstb_o  <= 1'b0;
      end else begin
         array_wstb_o <= 1'b0;
         if (wr_go && wstb0_q && wsel == SEL_ADATA && apc_r.latch) begin
            array_addr_o  <= aaddr_r;
            array_wdata_o <= wdata_q;
            array_wstb_o  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         array_latch_mode_o <= 1'b0;
         array_vpp_o        <= 1'b0;
         option_vpp_o       <= 1'b0;
         cell_vpp_o         <= 1'b0;
      end else begin
         array_latch_mode_o <= apc_r.latch;
         array_vpp_o        <= apc_r.power;
         option_vpp_o       <= apc_r.opt_power;
         cell_vpp_o         <= pgm_r;
      end
   end

   // nonvolatile storage: no reset; uv erase clears, programming only sets
   always_ff @(posedge aclk) begin
      if (nv_erase) begin
         cells_r <= 64'h0;
      end else if (cell_vpp_o && vpp_applied) begin
         cells_r[cell_index_of(bsel_r)] <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (nv_erase) begin
         opt_nv_r <= 8'h00;
      end else if (option_vpp_o && vpp_applied) begin
         opt_nv_r <= opt_nv_r | opt_pend_r;
      end
   end

   // sense amplifier; deliberately outside reset
   always_ff @(posedge aclk) begin
      sensed_r <= cells_r[cell_index_of(bsel_r)];
   end

   // option decode mirrors nonvolatile bits, so it is not reset either
   always_ff @(posedge aclk) begin
      option_bits_o       <= opt_nv_r;
      pulldown_en_o       <= opt_nv_r[OPT_PDI] ? 16'h0000
                             : pulldown_req;
      stop_delay_cycles_o <= opt_nv_r[OPT_DELAY] ? STOP_DLY_LONG
                             : STOP_DLY_SHORT;
      irq_level_sense_o   <= opt_nv_r[OPT_LEVEL];
   end

   always_comb begin
      rd_val = 8'h00;
      rd_err = 1'b0;
      case (reg_sel(araddr))
         SEL_BSEL:  rd_val = bsel_r;
         SEL_PSC: begin
            rd_val[PSC_SENSE] = sensed_r;
            rd_val[PSC_PGM]   = pgm_r;
            rd_val[PSC_ROWZ]  = (bsel_r[2:0] == 3'h0);
         end
         SEL_APC: begin
            rd_val[APC_LATCH]  = apc_r.latch;
            rd_val[APC_OPTPWR] = apc_r.opt_power;
            rd_val[APC_POWER]  = apc_r.power;
         end
         SEL_OPT:   rd_val = opt_nv_r;
         SEL_AADDR: rd_val = aaddr_r[7:0];
         SEL_ADATA: rd_val = apc_r.latch ? 8'h00 : array_rdata;
         default:   rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {24'h0, rd_val};
         rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // assertions
   logic ar_psc;
   logic ar_adata;
   assign ar_psc   = arvalid && arready && reg_sel(araddr) == SEL_PSC;
   assign ar_adata = arvalid && arready && reg_sel(araddr) == SEL_ADATA;

   sequence s_apc_write;
      wr_go && wstb0_q && wsel == SEL_APC;
   endsequence

   sequence s_bsel_write;
      wr_go && wstb0_q && wsel == SEL_BSEL;
   endsequence

   property p_sel_reset;
      @(posedge aclk) $rose(aresetn) |-> bsel_r == 8'h00;
   endproperty
   a_sel_reset: assert property (p_sel_reset)
      else $error("select not cleared by reset");

   property p_spare_store;
      @(posedge aclk) disable iff (!aresetn)
      s_bsel_write |=> bsel_r[7:6] == $past(wdata_q[7:6]);
   endproperty
   a_spare_store: assert property (p_spare_store)
      else $error("spare select bits not stored");

   property p_row_zero;
      @(posedge aclk) disable iff (!aresetn)
      ar_psc |=> rdata[PSC_ROWZ] == ($past(bsel_r[2:0]) == 3'h0);
   endproperty
   a_row_zero: assert property (p_row_zero)
      else $error("row zero flag wrong");

   property p_cell_prog;
      @(posedge aclk) disable iff (!aresetn)
      pgm_r && !nv_erase ##1 vpp_applied && !nv_erase
         |=> cells_r[cell_index_of($past(bsel_r))];
   endproperty
   a_cell_prog: assert property (p_cell_prog)
      else $error("selected cell not programmed");

   property p_erase;
      @(posedge aclk) nv_erase |=> cells_r == 64'h0 && opt_nv_r == 8'h00;
   endproperty
   a_erase: assert property (p_erase)
      else $error("erase left bits set");

   property p_power_gate;
      @(posedge aclk) disable iff (!aresetn)
      s_apc_write ##0 !apc_r.latch |=> (!apc_r.power)[*2];
   endproperty
   a_power_gate: assert property (p_power_gate)
      else $error("power set without prior latch");

   property p_latch_clear;
      @(posedge aclk) disable iff (!aresetn)
      s_apc_write ##0 !wdata_q[APC_LATCH] |=> !apc_r.latch && !apc_r.power
         ##1 !array_vpp_o;
   endproperty
   a_latch_clear: assert property (p_latch_clear)
      else $error("latch clear kept power");

   property p_latched_read;
      @(posedge aclk) disable iff (!aresetn)
      ar_adata && apc_r.latch |=> rdata == 32'h0;
   endproperty
   a_latched_read: assert property (p_latched_read)
      else $error("array data visible in latch mode");

   property p_pulldown;
      @(posedge aclk) disable iff (!aresetn)
      $past(opt_nv_r[OPT_PDI]) |-> pulldown_en_o == 16'h0000;
   endproperty
   a_pulldown: assert property (p_pulldown)
      else $error("pulldown not inhibited");

   property p_stop_delay;
      @(posedge aclk) disable iff (!aresetn)
      ##1 stop_delay_cycles_o == ($past(opt_nv_r[OPT_DELAY]) ? 12'hfe0
                                                             : 12'h010);
   endproperty
   a_stop_delay: assert property (p_stop_delay)
      else $error("stop delay mismatch");

endmodule // npc_nvm_ctrl
`default_nettype wire

/* testbench/tb.sv */
`default_nettype none
module tb
   import npc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // bus and side signals
   logic                aclk, aresetn, awvalid, awready, wvalid, wready;
   logic                bvalid, bready, arvalid, arready, rvalid, rready;
   logic                vpp_applied, nv_erase, array_wstb_o;
   logic                array_latch_mode_o, array_vpp_o, option_vpp_o;
   logic                cell_vpp_o, irq_level_sense_o;
   logic [1:0]          bresp, rresp, lresp;
   logic [3:0]          wstrb;
   logic [7:0]          awaddr, araddr, array_rdata, array_wdata_o;
   logic [7:0]          option_bits_o, stb_data;
   logic [11:0]         stop_delay_cycles_o;
   logic [ARRAY_AW-1:0] array_addr_o, stb_addr;
   logic [15:0]         pulldown_req, pulldown_en_o;
   logic [31:0]         wdata, rdata;
   int                  num_errors = 0;
   int                  tests_run = 0;
   int                  stb_cnt = 0;

   npc_nvm_ctrl npc_nvm_ctrl_i (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .vpp_applied, .nv_erase,
      .array_rdata, .array_addr_o, .array_wdata_o, .array_wstb_o,
      .array_latch_mode_o, .array_vpp_o, .option_vpp_o, .cell_vpp_o,
      .pulldown_req, .pulldown_en_o, .option_bits_o, .stop_delay_cycles_o,
      .irq_level_sense_o
   );

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // the strobe lasts one cycle, so count it on every edge
   always @(posedge aclk) begin
      if (array_wstb_o === 1'b1) begin
         stb_cnt <= stb_cnt + 1;
         stb_data <= array_wdata_o;
         stb_addr <= array_addr_o;
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bready && bvalid === 1'b1) begin
            bready <= 1'b0;
            lresp = bresp;
         end
      end while (awvalid || wvalid || bready);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rready && rvalid === 1'b1) begin
            rready <= 1'b0;
            d = rdata[7:0];
            lresp = rresp;
         end
      end while (arvalid || rready);
   endtask

   // response code and low byte are judged together
   task automatic rchk(input logic [7:0] a, e, input string what);
      logic [7:0] d;
      rd(a, d);
      chk(what, {lresp, d}, {RESP_OKAY, e});
   endtask

   task automatic t_reset();
      rchk(OFS_BSEL, BSEL_RESET, "select");
      rchk(OFS_PSC, 8'h01, "status");
      rchk(OFS_APC, 8'h00, "prog ctl");
      rchk(OFS_OPT, 8'h00, "option");
      chk("stop delay", stop_delay_cycles_o, 12'h010);
      chk("pulldown", pulldown_en_o, 16'hffff);
      chk("level", irq_level_sense_o, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_select();
      wr(OFS_BSEL, 8'hc7);
      rchk(OFS_BSEL, 8'hc7, "select");
      rchk(OFS_PSC, 8'h00, "row flag");
      wr(OFS_BSEL, 8'hc8);
      rchk(OFS_PSC, 8'h01, "row wrap");
      $display("test select done");
   endtask

   task automatic t_cell();
      // no supply on the pin: the program bit alone must not burn a cell
      vpp_applied <= 1'b0;
      wr(OFS_BSEL, 8'h3e);
      wr(OFS_PSC, 8'h02);
      repeat (2) @(posedge aclk);
      wr(OFS_PSC, 8'h00);
      vpp_applied <= 1'b1;
      wr(OFS_BSEL, 8'h3f);
      wr(OFS_PSC, 8'hff);
      repeat (2) @(posedge aclk);
      chk("cell vpp", cell_vpp_o, 1'b1);
      rchk(OFS_PSC, 8'h82, "status");
      wr(OFS_PSC, 8'h00);
      repeat (2) @(posedge aclk);
      chk("cell vpp", cell_vpp_o, 1'b0);
      wr(OFS_BSEL, 8'h37);
      rchk(OFS_PSC, 8'h00, "other col");
      wr(OFS_BSEL, 8'h3e);
      rchk(OFS_PSC, 8'h00, "other row");
      wr(OFS_BSEL, 8'h3f);
      rchk(OFS_PSC, 8'h80, "sensed");
      $display("test cell done");
   endtask

   task automatic t_array();
      wr(OFS_APC, 8'h05);
      rchk(OFS_APC, 8'h04, "both set");
      chk("latch mode", array_latch_mode_o, 1'b1);
      rchk(OFS_ADATA, 8'h00, "latched read");
      wr(OFS_AADDR, 8'h9c);
      rchk(OFS_AADDR, 8'h9c, "array addr");
      wr(OFS_ADATA, 8'h5a);
      repeat (3) @(posedge aclk);
      chk("strobes", stb_cnt, 1);
      chk("latched data", stb_data, 8'h5a);
      chk("latched addr", stb_addr, 13'h009c);
      wr(OFS_APC, 8'h05);
      rchk(OFS_APC, 8'h05, "power");
      chk("array vpp", array_vpp_o, 1'b1);
      wr(OFS_APC, 8'h01);
      rchk(OFS_APC, 8'h00, "latch clear");
      chk("array vpp", array_vpp_o, 1'b0);
      rchk(OFS_ADATA, 8'ha5, "array read");
      wr(OFS_APC, 8'h01);
      rchk(OFS_APC, 8'h00, "no latch");
      wr(OFS_ADATA, 8'h33);
      repeat (3) @(posedge aclk);
      chk("strobes", stb_cnt, 1);
      $display("test array done");
   endtask

   task automatic t_option();
      wr(OFS_OPT, 8'h43);
      wr(OFS_APC, 8'h02);
      repeat (2) @(posedge aclk);
      chk("option vpp", option_vpp_o, 1'b1);
      wr(OFS_APC, 8'h00);
      rchk(OFS_OPT, 8'h43, "option");
      chk("option bits", option_bits_o, 8'h43);
      chk("stop delay", stop_delay_cycles_o, 12'hfe0);
      chk("pulldown", pulldown_en_o, 16'h0000);
      chk("level", irq_level_sense_o, 1'b1);
      $display("test option done");
   endtask

   // a second reset must spare the nonvolatile parts
   task automatic t_rereset();
      logic [7:0] d;
      wr(OFS_BSEL, 8'hc7);
      wr(OFS_APC, 8'h04);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(OFS_OPT, 8'h43, "option");
      rchk(OFS_BSEL, 8'h00, "select");
      rchk(OFS_APC, 8'h00, "prog ctl");
      wr(OFS_BSEL, 8'h3f);
      rchk(OFS_PSC, 8'h80, "sensed");
      rd(8'h18, d);
      chk("unmapped rd", {lresp, d}, {RESP_SLVERR, 8'h00});
      wr(8'h1c, 8'hff);
      chk("unmapped wr", lresp, RESP_SLVERR);
      $display("test rereset done");
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge aclk);
      num_errors++;
      summarize();
   end

   initial begin
      aresetn = 1'b0;
      nv_erase = 1'b1;
      vpp_applied = 1'b1;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h00000000;
      wstrb = 4'h0;
      array_rdata = 8'ha5;
      pulldown_req = 16'hffff;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      nv_erase <= 1'b0;
      t_reset();
      t_select();
      t_cell();
      t_array();
      t_option();
      t_rereset();
      summarize();
   end
endmodule // tb
`default_nettype wire
